// ===== dpi_pkg.sv
`default_nettype none
package dpi_pkg;
	localparam int          CLK_HZ        = 100_000_000;
	localparam int          TICK_FAST_HZ  = 2_000_000;
	localparam int          TICK_SLOW_HZ  = 32768;
	// Slow tick rounds down: 3051 cycles, a little above 32768 Hz
	localparam int          TICK_FAST_CYC = CLK_HZ / TICK_FAST_HZ;
	localparam int          TICK_SLOW_CYC = CLK_HZ / TICK_SLOW_HZ;
	localparam int          DIV_W         = 12;

	localparam int          PORT_CNT      = 6;
	localparam int          PORT_W        = 8;
	localparam int          PORT_C_CONN1  = 2;
	localparam int          PORT_C_CONN2  = 5;
	localparam int          PC_BIT0       = 0;
	localparam int          PC_BIT3       = 3;
	localparam int          PC_BIT7       = 7;

	localparam logic [1:0]  SEL_PC3       = 2'h2;
	localparam logic [1:0]  SEL_PC3_NOT7  = 2'h0;

	localparam int          CHAN_CNT      = 4;
	localparam int          CHAN_A        = 0;
	localparam int          CHAN_B        = 1;
	localparam int          CHAN_C        = 2;
	localparam int          CHAN_D        = 3;

	localparam logic [5:0]  DIR_RESET     = 6'h00;
	localparam logic [47:0] LATCH_RESET   = 48'h0;
	localparam int          SYNC_STAGES   = 3;
endpackage : dpi_pkg
`default_nettype wire

// ===== dpi_pin_sync.sv
`default_nettype none
module dpi_pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	// A bit is accepted only once stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			out_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : out_q[i];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_q   <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
			out_q    <= '0;
		end else begin
			meta_q   <= pinIn;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
			out_q    <= out_d;
		end
	end

	assign pinOut = out_q;
endmodule : dpi_pin_sync
`default_nettype wire

// ===== dpi_port_irq.sv
`default_nettype none
module dpi_port_irq
	import dpi_pkg::*;
#(
	parameter int CNT0_W = 16,
	parameter int TMR_W  = 32
) (
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	input  wire logic                        ioEnable,
	input  wire logic [PORT_CNT-1:0]         dirWrite,
	input  wire logic [PORT_CNT-1:0]         dirWriteData,
	input  wire logic [PORT_CNT-1:0]         portWrite,
	input  wire logic [PORT_W-1:0]           portWriteData,
	input  wire logic [PORT_CNT*PORT_W-1:0]  portPinIn,
	output logic      [PORT_CNT*PORT_W-1:0]  portPinOut,
	output logic      [PORT_CNT*PORT_W-1:0]  portPinOe_n,
	output logic      [PORT_CNT*PORT_W-1:0]  portReadData,
	output logic      [PORT_CNT-1:0]         portDirOut,
	input  wire logic                        counter1ClockSelect,
	input  wire logic                        counter0InputInvert,
	input  wire logic                        srcASelectLo,
	input  wire logic                        srcASelectHi,
	input  wire logic                        srcBSelectLo,
	input  wire logic                        srcBSelectHi,
	input  wire logic [CHAN_CNT-1:0]         srcGate,
	input  wire logic [CHAN_CNT-1:0]         srcPolarity,
	input  wire logic [CNT0_W-1:0]           counter0Reload,
	input  wire logic [TMR_W-1:0]            timerReload,
	output logic      [CHAN_CNT-1:0]         chanStatus,
	output logic                             irq_n
);
	localparam int PW = PORT_CNT * PORT_W;

	logic [PW-1:0]       pinSync;
	logic [PORT_CNT-1:0] dir_q, dir_d;
	logic [PW-1:0]       latch_q, latch_d;
	logic [PW-1:0]       dirExp;
	logic [PW-1:0]       pinOut_q, pinOut_d;
	logic [PW-1:0]       pinOeN_q, pinOeN_d;
	logic [PW-1:0]       read_q, read_d;

	dpi_pin_sync #(
		.WIDTH (PW)
	) uPinSync (
		.clk     (clk),
		.reset_n (reset_n),
		.pinIn   (portPinIn),
		.pinOut  (pinSync)
	);

	// Port direction, latch, drivers and read-back
	always_comb begin
		dir_d   = dir_q;
		latch_d = latch_q;
		for (int p = 0; p < PORT_CNT; p++) begin
			dirExp[p*PORT_W +: PORT_W] = {PORT_W{dir_q[p]}};
			if (ioEnable) begin
				if (dirWrite[p]) begin
					dir_d[p] = dirWriteData[p];
				end
				if (portWrite[p]) begin
					latch_d[p*PORT_W +: PORT_W] = portWriteData;
				end
			end
		end
		// Drivers follow the latch one cycle later, whatever the port direction
		pinOut_d = latch_q;
		pinOeN_d = ioEnable ? ~dirExp : '1;
		if (!ioEnable) begin
			read_d = '0;
		end else begin
			read_d = (dirExp & latch_q) | (~dirExp & pinSync);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dir_q    <= DIR_RESET;
			latch_q  <= LATCH_RESET;
			pinOut_q <= LATCH_RESET;
			pinOeN_q <= '1;
			read_q   <= '0;
		end else begin
			dir_q    <= dir_d;
			latch_q  <= latch_d;
			pinOut_q <= pinOut_d;
			pinOeN_q <= pinOeN_d;
			read_q   <= read_d;
		end
	end

	// Counter 1 clock: a tick strobe divided from the bus clock
	logic [DIV_W-1:0] div_q, div_d;
	logic             tick_q, tick_d;
	logic [DIV_W-1:0] divLast;

	always_comb begin
		divLast = counter1ClockSelect ? DIV_W'(TICK_SLOW_CYC - 1)
		                              : DIV_W'(TICK_FAST_CYC - 1);
		if (div_q >= divLast) begin
			div_d  = '0;
			tick_d = 1'b1;
		end else begin
			div_d  = div_q + 1'b1;
			tick_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

	// Counters run in square-wave mode: the output toggles at each
	// terminal count, which suits the polarity-toggling service scheme.
	logic              cnt0In, cnt0InPrev_q;
	logic [CNT0_W-1:0] cnt0_q, cnt0_d;
	logic              cnt0Out_q, cnt0Out_d;
	logic [TMR_W-1:0]  tmr_q, tmr_d;
	logic              tmrOut_q, tmrOut_d;

	always_comb begin
		cnt0In = pinSync[PORT_C_CONN1*PORT_W + PC_BIT0]
		         ^ counter0InputInvert;
		cnt0_d    = cnt0_q;
		cnt0Out_d = cnt0Out_q;
		tmr_d     = tmr_q;
		tmrOut_d  = tmrOut_q;
		if (cnt0In && !cnt0InPrev_q) begin
			if (cnt0_q == '0) begin
				cnt0_d    = counter0Reload;
				cnt0Out_d = ~cnt0Out_q;
			end else begin
				cnt0_d = cnt0_q - 1'b1;
			end
		end
		if (tick_q) begin
			if (tmr_q == '0) begin
				tmr_d    = timerReload;
				tmrOut_d = ~tmrOut_q;
			end else begin
				tmr_d = tmr_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			// Track the level in reset so release makes no false edge
			cnt0InPrev_q <= cnt0In;
			cnt0_q       <= '0;
			cnt0Out_q    <= 1'b0;
			tmr_q        <= '0;
			tmrOut_q     <= 1'b0;
		end else begin
			cnt0InPrev_q <= cnt0In;
			cnt0_q       <= cnt0_d;
			cnt0Out_q    <= cnt0Out_d;
			tmr_q        <= tmr_d;
			tmrOut_q     <= tmrOut_d;
		end
	end

	// Interrupt channels
	logic                port2C3, port2C7, port5C3, port5C7;
	logic [CHAN_CNT-1:0] chanSrc, chanLevel, chanGated;
	logic [CHAN_CNT-1:0] status_q;
	logic                irqN_q;

	always_comb begin
		port2C3 = pinSync[PORT_C_CONN1*PORT_W + PC_BIT3];
		port2C7 = pinSync[PORT_C_CONN1*PORT_W + PC_BIT7];
		port5C3 = pinSync[PORT_C_CONN2*PORT_W + PC_BIT3];
		port5C7 = pinSync[PORT_C_CONN2*PORT_W + PC_BIT7];
		// Codes 01 and 11 both leave the source at zero
		unique case ({srcASelectHi, srcASelectLo})
			SEL_PC3:      chanSrc[CHAN_A] = port2C3;
			SEL_PC3_NOT7: chanSrc[CHAN_A] = port2C3 & ~port2C7;
			default:      chanSrc[CHAN_A] = 1'b0;
		endcase
		unique case ({srcBSelectHi, srcBSelectLo})
			SEL_PC3:      chanSrc[CHAN_B] = port5C3;
			SEL_PC3_NOT7: chanSrc[CHAN_B] = port5C3 & ~port5C7;
			default:      chanSrc[CHAN_B] = 1'b0;
		endcase
		chanSrc[CHAN_C] = cnt0Out_q;
		chanSrc[CHAN_D] = tmrOut_q;
		chanLevel = ~(chanSrc ^ srcPolarity);
		chanGated = chanLevel & srcGate;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			status_q <= '0;
			irqN_q   <= 1'b1;
		end else begin
			status_q <= chanLevel;
			// One shared line: overlapping channels form one low span
			irqN_q   <= ~(|chanGated);
		end
	end

	assign portPinOut   = pinOut_q;
	assign portPinOe_n  = pinOeN_q;
	assign portReadData = read_q;
	assign portDirOut   = dir_q;
	assign chanStatus   = status_q;
	assign irq_n        = irqN_q;

	a_disable_drivers: assert property (@(posedge clk)
		disable iff (!reset_n)
		!ioEnable |=> (portPinOe_n == '1) && (portReadData == '0))
		else $error("drivers or reads active while disabled");

	a_enable_drive: assert property (@(posedge clk)
		disable iff (!reset_n)
		ioEnable |=> portPinOe_n == ~$past(dirExp))
		else $error("driver enables do not follow direction");

	a_read_input: assert property (@(posedge clk)
		disable iff (!reset_n)
		ioEnable && !dir_q[PORT_C_CONN1] |=>
		portReadData[PORT_C_CONN1*PORT_W +: PORT_W]
		== $past(pinSync[PORT_C_CONN1*PORT_W +: PORT_W]))
		else $error("input port read does not show lines");

	a_read_latch: assert property (@(posedge clk)
		disable iff (!reset_n)
		ioEnable && dir_q[0] |=>
		portReadData[PORT_W-1:0] == $past(latch_q[PORT_W-1:0]))
		else $error("output port read does not show latch");

	a_latch_hidden: assert property (@(posedge clk)
		disable iff (!reset_n)
		ioEnable && portWrite[0] && !dir_q[0] && !dirWrite[0] |=>
		latch_q[PORT_W-1:0] == $past(portWriteData) ##1
		portPinOe_n[PORT_W-1:0] == '1)
		else $error("input port write drove lines or missed latch");

	a_latch_drive: assert property (@(posedge clk)
		disable iff (!reset_n)
		ioEnable && dir_q[1] |=>
		portPinOut[PORT_W +: PORT_W] == $past(latch_q[PORT_W +: PORT_W]))
		else $error("output port does not drive its latch");

	a_irq_merge: assert property (@(posedge clk)
		disable iff (!reset_n)
		(|chanGated) |=> !irq_n ##1 (irq_n == !$past(|chanGated)))
		else $error("combined interrupt does not follow channels");

	a_irq_idle: assert property (@(posedge clk)
		disable iff (!reset_n)
		!(|chanGated) |=> irq_n)
		else $error("interrupt low with no gated channel");

	a_gate_blocks: assert property (@(posedge clk)
		disable iff (!reset_n)
		(srcGate == '0) |=> irq_n)
		else $error("interrupt raised with all gates closed");

	a_sel_disabled: assert property (@(posedge clk)
		disable iff (!reset_n)
		srcASelectHi && srcASelectLo && !srcPolarity[CHAN_A] |=>
		chanStatus[CHAN_A])
		else $error("select code 11 did not disable source");

	a_sel_pc3: assert property (@(posedge clk)
		disable iff (!reset_n)
		srcASelectHi && !srcASelectLo && srcPolarity[CHAN_A] |=>
		chanStatus[CHAN_A] == $past(port2C3))
		else $error("channel A does not follow bit 3");

	a_sel_a_and: assert property (@(posedge clk)
		disable iff (!reset_n)
		!srcASelectHi && !srcASelectLo && srcPolarity[CHAN_A] |=>
		chanStatus[CHAN_A] == ($past(port2C3) & ~$past(port2C7)))
		else $error("channel A does not follow bit 3 and not bit 7");

	a_sel_b_pc3: assert property (@(posedge clk)
		disable iff (!reset_n)
		srcBSelectHi && !srcBSelectLo && srcPolarity[CHAN_B] |=>
		chanStatus[CHAN_B] == $past(port5C3))
		else $error("channel B does not follow bit 3");

	a_cnt0_toggle: assert property (@(posedge clk)
		disable iff (!reset_n)
		cnt0In && !cnt0InPrev_q && (cnt0_q == '0) |=>
		cnt0Out_q != $past(cnt0Out_q))
		else $error("event counter output did not toggle at zero");

	a_tick_fast: assert property (@(posedge clk)
		disable iff (!reset_n)
		tick_q && !counter1ClockSelect |=> !tick_q [*8])
		else $error("fast tick spacing too short");

	a_reset_inputs: assert property (@(posedge clk)
		!reset_n |=> (portPinOe_n == '1) && (portDirOut == '0))
		else $error("ports not released to input after reset");
endmodule : dpi_port_irq
`default_nettype wire

// ===== dpi_field_model.sv
`default_nettype none
module dpi_field_model
	import dpi_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic [PORT_CNT*PORT_W-1:0] extLevel,
	input  wire logic [PORT_CNT*PORT_W-1:0] pinOut,
	input  wire logic [PORT_CNT*PORT_W-1:0] pinOe_n,
	output logic      [PORT_CNT*PORT_W-1:0] pinIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [PORT_CNT*PORT_W-1:0] extLevel_q;
	// Field lines start low and follow extLevel one clock later
	initial extLevel_q = '0;
	always @(posedge clk) begin
		extLevel_q <= extLevel;
	end
	// A released line shows the field level, a driven one the latch
	always_comb begin
		for (int i = 0; i < PORT_CNT*PORT_W; i++) begin
			pinIn[i] = pinOe_n[i] ? extLevel_q[i] : pinOut[i];
		end
	end
endmodule : dpi_field_model
`default_nettype wire

// ===== dpi_port_irq_tb.sv
`default_nettype none
module dpi_port_irq_tb
	import dpi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = PORT_CNT*PORT_W;
	logic                clk, reset_n, ioEnable, irq_n;
	logic                selALo, selAHi, selBLo, selBHi, x, v, g;
	logic [PORT_CNT-1:0] dirWrite, dirWriteData, portWrite, dirOut, dirM;
	logic [PORT_W-1:0]   portWriteData;
	logic [PORT_W-1:0]   latchM [PORT_CNT];
	logic [W-1:0]        pinIn, pinOut, pinOe_n, readData, extLevel, e;
	logic [CHAN_CNT-1:0] gate, pol, chanStatus;
	logic [1:0]          sel;
	logic                c1Sel, c0Inv, mo;
	logic [15:0]         c0Rld;
	int                  err_count, cmp_count, seed, falls, p, ch, mc, gap;

	dpi_port_irq i_dpi_port_irq (.clk(clk), .reset_n(reset_n),
		.ioEnable(ioEnable), .dirWrite(dirWrite),
		.dirWriteData(dirWriteData), .portWrite(portWrite),
		.portWriteData(portWriteData), .portPinIn(pinIn),
		.portPinOut(pinOut), .portPinOe_n(pinOe_n),
		.portReadData(readData), .portDirOut(dirOut),
		.counter1ClockSelect(c1Sel), .counter0InputInvert(c0Inv),
		.srcASelectLo(selALo), .srcASelectHi(selAHi),
		.srcBSelectLo(selBLo), .srcBSelectHi(selBHi), .srcGate(gate),
		.srcPolarity(pol), .counter0Reload(c0Rld),
		.timerReload(32'h0000_0000), .chanStatus(chanStatus),
		.irq_n(irq_n));
	dpi_field_model i_dpi_field_model (.clk(clk),
		.extLevel(extLevel), .pinOut(pinOut), .pinOe_n(pinOe_n),
		.pinIn(pinIn));

	task automatic chk(input string n, input logic [W-1:0] a, b);
		cmp_count++;
		if (b !== a) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, a, b);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Ends on the falling edge so that checks see settled outputs
	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : ticks
	task automatic tickGap(output int n);
		logic s;
		@(negedge clk);
		s = chanStatus[CHAN_D];
		while (chanStatus[CHAN_D] === s) @(negedge clk);
		s = chanStatus[CHAN_D];
		n = 0;
		while (chanStatus[CHAN_D] === s) begin
			@(negedge clk);
			n++;
		end
	endtask : tickGap
	task automatic drv(input logic [W-1:0] d);
		@(posedge clk);
		extLevel <= d;
		ticks(10);
	endtask : drv
	task automatic setPort(input int q, input logic [7:0] d, input logic wl,
		input logic o);
		@(posedge clk);
		portWrite     <= wl ? PORT_CNT'(1 << q) : '0;
		portWriteData <= d;
		@(posedge clk);
		portWrite    <= '0;
		dirWrite     <= PORT_CNT'(1 << q);
		dirWriteData <= {PORT_CNT{o}};
		@(posedge clk);
		dirWrite <= '0;
		if (ioEnable && wl) latchM[q] = d;
		if (ioEnable) dirM[q] = o;
		ticks(10);
	endtask : setPort
	task automatic chkPorts();
		logic [W-1:0] rd, oe, lt;
		for (int k = 0; k < PORT_CNT; k++) begin
			oe[k*8+:8] = {8{~(dirM[k] & ioEnable)}};
			lt[k*8+:8] = latchM[k];
			rd[k*8+:8] = !ioEnable ? 8'h00 : dirM[k] ? latchM[k] :
				extLevel[k*8+:8];
		end
		chk("read", rd, readData);
		chk("oe", oe, pinOe_n);
		chk("drive", lt & ~oe, pinOut & ~oe);
		chk("dir", W'(dirM), W'(dirOut));
	endtask : chkPorts
	function automatic logic expChan(input logic [1:0] s,
		input logic b3, b7, pl);
		logic r;
		r = (s == SEL_PC3) ? b3 : (s == SEL_PC3_NOT7) ? (b3 & ~b7) : 1'b0;
		return pl ? r : ~r;
	endfunction : expChan

	always @(negedge irq_n) begin
		if (reset_n) falls++;
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#200_000;
		err_count++;
		report_and_stop();
	end
	initial begin
		{reset_n, ioEnable, dirWrite, dirWriteData, portWrite} = '0;
		{portWriteData, extLevel, selALo, selAHi, selBLo, selBHi} = '0;
		{gate, pol, dirM, c1Sel, c0Inv, c0Rld} = '0;
		seed = 72548;
		for (int k = 0; k < PORT_CNT; k++) latchM[k] = 8'h00;
		ticks(15);
		@(posedge clk);
		reset_n <= 1'b1;
		ticks(4);
		chkPorts();
		chk("irq", W'(1'b1), W'(irq_n));
		setPort(0, 8'ha5, 1'b1, 1'b1);
		chkPorts();
		@(posedge clk);
		ioEnable <= 1'b1;
		extLevel <= W'(48'h5a5a_c3c3_0f0f);
		ticks(10);
		chkPorts();
		setPort(1, 8'h3c, 1'b1, 1'b0);
		chkPorts();
		setPort(1, 8'h00, 1'b0, 1'b1);
		chkPorts();
		for (int i = 0; i < 64; i++) begin
			ch = i >> 5;
			sel = 2'(i >> 3);
			e = extLevel;
			e[ch ? 43 : 19] = i[1];
			e[ch ? 47 : 23] = i[0];
			g = 1'($random(seed));
			@(posedge clk);
			extLevel       <= e;
			{selAHi, selALo} <= sel;
			{selBHi, selBLo} <= sel;
			pol            <= {2'b00, i[2], i[2]};
			gate           <= ch ? {2'b00, g, 1'b0} : {3'b000, g};
			ticks(10);
			x = expChan(sel, i[1], i[0], i[2]);
			v = ~(x & g);
			chk("status", W'(x), W'(chanStatus[ch]));
			chk("irq", W'(v), W'(irq_n));
		end
		@(posedge clk);
		{selAHi, selALo, selBHi, selBLo} <= {SEL_PC3, SEL_PC3};
		pol  <= 4'hf;
		gate <= 4'h3;
		e = '0;
		drv(e);
		falls = 0;
		e[19] = 1'b1;
		e[43] = 1'b1;
		drv(e);
		chk("irq", W'(1'b0), W'(irq_n));
		e[19] = 1'b0;
		drv(e);
		chk("irq", W'(1'b0), W'(irq_n));
		e[43] = 1'b0;
		drv(e);
		chk("irq", W'(1'b1), W'(irq_n));
		chk("falls", W'(1), W'(falls));
		e[19] = 1'b1;
		drv(e);
		chk("status", W'(1'b1), W'(chanStatus[CHAN_A]));
		@(posedge clk);
		pol <= pol ^ 4'h1;
		ticks(4);
		chk("irq", W'(1'b1), W'(irq_n));
		e[19] = 1'b0;
		drv(e);
		chk("irq", W'(1'b0), W'(irq_n));
		@(posedge clk);
		pol <= pol ^ 4'h1;
		ticks(4);
		chk("irq", W'(1'b1), W'(irq_n));
		for (int i = 0; i < 12; i++) begin
			p = {$random(seed)} % PORT_CNT;
			e = {16'($random(seed)), 32'($random(seed))};
			@(posedge clk);
			extLevel <= e;
			setPort(p, 8'($random(seed)), 1'b1, 1'($random(seed)));
			chkPorts();
		end
		@(posedge clk);
		ioEnable <= 1'b0;
		ticks(10);
		chkPorts();
		@(posedge clk);
		reset_n  <= 1'b0;
		ioEnable <= 1'b1;
		extLevel <= '0;
		ticks(15);
		@(posedge clk);
		reset_n <= 1'b1;
		pol     <= 4'h4;
		gate    <= 4'h4;
		dirM = '0;
		latchM = '{default: 8'h00};
		e = '0;
		drv(e);
		chkPorts();
		e[16] = 1'b1;
		drv(e);
		chk("count", W'(1'b1), W'(chanStatus[CHAN_C]));
		chk("irq", W'(1'b0), W'(irq_n));
		e[16] = 1'b0;
		drv(e);
		chk("count", W'(1'b1), W'(chanStatus[CHAN_C]));
		e[16] = 1'b1;
		drv(e);
		chk("count", W'(1'b0), W'(chanStatus[CHAN_C]));
		// Inverted input: each falling pin edge is one event, reload 2
		@(posedge clk);
		c0Inv <= 1'b1;
		c0Rld <= 16'h0002;
		mc = 0;
		mo = 1'b0;
		for (int k = 0; k < 7; k++) begin
			e[16] = ~e[16];
			if (!e[16]) begin
				mo = (mc == 0) ? ~mo : mo;
				mc = (mc == 0) ? 2 : mc - 1;
			end
			drv(e);
			chk("count", W'(mo), W'(chanStatus[CHAN_C]));
		end
		tickGap(gap);
		chk("tick", W'(CLK_HZ / TICK_FAST_HZ), W'(gap));
		@(posedge clk);
		c1Sel <= 1'b1;
		ticks(4);
		tickGap(gap);
		chk("tick", W'(CLK_HZ / TICK_SLOW_HZ), W'(gap));
		report_and_stop();
	end
endmodule : dpi_port_irq_tb
`default_nettype wire
